/* design/iss_ptr_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Computes effective address and next pointer for one store
module iss_ptr_unit #(
   parameter int PTR_W = iss_pkg::PTR_W
) (
   input wire logic [PTR_W-1:0] ptr_i,
   input wire logic [1:0] mode_i,
   input wire logic rel_i,
   input wire logic [5:0] offset_i,
   output logic [PTR_W-1:0] ea_o,
   output logic [PTR_W-1:0] ptr_next_o
);
   logic [PTR_W-1:0] inc;
   logic [PTR_W-1:0] dec;
   logic [PTR_W-1:0] ofs_ext;

   // A pointer no wider than the offset cannot take a signed step
   if (PTR_W <= iss_pkg::OFS_W)
   begin : g_bad_width
      $error("iss_ptr_unit: PTR_W must exceed the offset width");
   end

   // Plain modular add: carry out is dropped so the pointer wraps
   assign inc = ptr_i + PTR_W'(1);
   assign dec = ptr_i - PTR_W'(1);
   assign ofs_ext = PTR_W'($signed(offset_i));

   // Address and writeback selection
   always_comb
   begin
      ea_o = ptr_i;
      ptr_next_o = ptr_i;
      if (rel_i)
      begin
         ea_o = ptr_i + ofs_ext;
         ptr_next_o = ptr_i;
      end
      else
      begin
         unique case (mode_i)
            iss_pkg::MODE_PRE_INC:
            begin
               ea_o = inc;
               ptr_next_o = inc;
            end
            iss_pkg::MODE_PRE_DEC:
            begin
               ea_o = dec;
               ptr_next_o = dec;
            end
            iss_pkg::MODE_POST_INC:
            begin
               ea_o = ptr_i;
               ptr_next_o = inc;
            end
            iss_pkg::MODE_POST_DEC:
            begin
               ea_o = ptr_i;
               ptr_next_o = dec;
            end
         endcase
      end
   end
endmodule // iss_ptr_unit
`default_nettype wire

/* design/iss_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Indirect store writes working register through pointer
// - Mode field picks pre/post increment/decrement
// - Pointer is sixteen bits and wraps
// - Pointer update and store leave status
// - Alias has no storage; pointer target accessed
// - Soft reset resets device, clears cause flag
module iss_top (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire iss_pkg::iss_instr_s instr_i,
   input wire logic [7:0] w_reg_i,
   input wire logic [7:0] status_i,
   input wire logic ptr_load_i,
   input wire logic ptr_load_sel_i,
   input wire logic [15:0] ptr_load_val_i,
   output iss_pkg::iss_mem_wr_s mem_wr_o,
   output logic [15:0] ptr0_o,
   output logic [15:0] ptr1_o,
   output logic [7:0] status_o,
   output logic soft_reset_cause_flag_o,
   output logic dev_reset_o
);
   logic [15:0] file_pointer_reg_q [2];
   logic [15:0] ptr_sel;
   logic [15:0] ea;
   logic [15:0] ptr_next;
   logic is_store;
   logic is_rel;
   logic is_alias;
   logic is_srst;
   logic [1:0] srst_cnt_q;
   logic srst_busy;

   assign srst_busy = (srst_cnt_q != 2'h0);
   assign ptr_sel = file_pointer_reg_q[instr_i.sel];
   assign is_store = instr_valid_i && !srst_busy &&
      (instr_i.op == iss_pkg::ISS_OP_STORE_MODE ||
       instr_i.op == iss_pkg::ISS_OP_STORE_REL);
   assign is_rel = (instr_i.op == iss_pkg::ISS_OP_STORE_REL);
   assign is_alias = instr_valid_i && !srst_busy &&
      (instr_i.op == iss_pkg::ISS_OP_ALIAS_WR);
   assign is_srst = instr_valid_i && !srst_busy &&
      (instr_i.op == iss_pkg::ISS_OP_SOFT_RESET);

   iss_ptr_unit #(
      .PTR_W(iss_pkg::PTR_W)
   ) u_ptr (
      .ptr_i(ptr_sel),
      .mode_i(instr_i.addr_update_field),
      .rel_i(is_rel),
      .offset_i(instr_i.offset),
      .ea_o(ea),
      .ptr_next_o(ptr_next)
   );

   // Memory write port; alias writes go to the pointer target itself
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         mem_wr_o <= '0;
      else if (is_store)
      begin
         mem_wr_o.en <= 1'b1;
         mem_wr_o.addr <= ea;
         mem_wr_o.data <= w_reg_i;
      end
      else if (is_alias)
      begin
         mem_wr_o.en <= 1'b1;
         mem_wr_o.addr <= ptr_sel;
         mem_wr_o.data <= w_reg_i;
      end
      else
         mem_wr_o.en <= 1'b0;
   end

   // Pointer registers; soft reset returns them to reset value
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_ptr
         always_ff @(posedge ref_clk_i or posedge rst_i)
         begin
            if (rst_i)
               file_pointer_reg_q[g] <= iss_pkg::PTR_RST;
            else if (is_srst)
               file_pointer_reg_q[g] <= iss_pkg::PTR_RST;
            else if (is_store && instr_i.sel == 1'(g))
               file_pointer_reg_q[g] <= ptr_next;
            // The device is in reset while the pulse stands: no loads
            else if (ptr_load_i && !srst_busy &&
               ptr_load_sel_i == 1'(g))
               file_pointer_reg_q[g] <= ptr_load_val_i;
         end
      end
   endgenerate

   // Pointer outputs registered
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr0_o <= iss_pkg::PTR_RST;
         ptr1_o <= iss_pkg::PTR_RST;
      end
      else
      begin
         ptr0_o <= file_pointer_reg_q[0];
         ptr1_o <= file_pointer_reg_q[1];
      end
   end

   // Status passes through untouched; stores never alter it.
   // A soft reset acts as a device reset, so status is cleared
   // for the whole pulse just as a pin reset would clear it.
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         status_o <= iss_pkg::STATUS_RST;
      else if (is_srst || srst_busy)
         status_o <= iss_pkg::STATUS_RST;
      else
         status_o <= status_i;
   end

   // Soft reset: stretched pulse so downstream logic sees a full reset
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         srst_cnt_q <= 2'h0;
      else if (is_srst)
         srst_cnt_q <= 2'(iss_pkg::SRST_CYCLES);
      else if (srst_busy)
         srst_cnt_q <= srst_cnt_q - 2'h1;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         dev_reset_o <= 1'b0;
      else
         dev_reset_o <= is_srst || (srst_cnt_q > 2'h1);
   end

   // Cause flag is active low: cleared by soft reset, set at power-up
   always_ff @(posedge ref_clk_i or posedge rst_i)
   begin
      if (rst_i)
         soft_reset_cause_flag_o <= 1'b1;
      else if (is_srst)
         soft_reset_cause_flag_o <= 1'b0;
   end
endmodule // iss_top
`default_nettype wire

/* include/iss_pkg.sv */
package iss_pkg;
   // Pointer, data and offset widths
   localparam int PTR_W = 16;
   localparam int DATA_W = 8;
   localparam int OFS_W = 6;
   // Address update field encodings
   localparam logic [1:0] MODE_PRE_INC = 2'h0;
   localparam logic [1:0] MODE_PRE_DEC = 2'h1;
   localparam logic [1:0] MODE_POST_INC = 2'h2;
   localparam logic [1:0] MODE_POST_DEC = 2'h3;
   // Opcode classes presented by the fetch stage
   typedef enum logic [2:0]
   {
      ISS_OP_NOP = 3'h0,
      ISS_OP_STORE_MODE = 3'h1,
      ISS_OP_STORE_REL = 3'h3,
      ISS_OP_ALIAS_WR = 3'h2,
      ISS_OP_SOFT_RESET = 3'h6
   } iss_op_e;
   // Reset values
   localparam logic [15:0] PTR_RST = 16'h0000;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // Soft reset pulse length in cycles
   localparam int SRST_CYCLES = 2;
   // Decoded instruction
   typedef struct packed
   {
      iss_op_e op;
      logic sel;
      logic [1:0] addr_update_field;
      logic [5:0] offset;
   } iss_instr_s;
   // Data memory write request
   typedef struct packed
   {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } iss_mem_wr_s;
endpackage

/* verif/iss_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_top_bench;
   logic clk = 0, rst = 1, v = 0, ld = 0, ls = 0;
   logic [15:0] lv = 0, p0, p1, e;
   logic [7:0] w = 0, st = 0, so;
   logic fl, dr;
   iss_pkg::iss_instr_s ins = '0;
   iss_pkg::iss_mem_wr_s wr;
   integer errors = 0, comparisons = 0, seed = 32'h42fe_fd28;
   // Clock at 20 MHz
   always #25 clk = ~clk;
   iss_top i_iss_top (.ref_clk_i(clk), .rst_i(rst), .instr_valid_i(v),
      .instr_i(ins), .w_reg_i(w), .status_i(st), .ptr_load_i(ld),
      .ptr_load_sel_i(ls), .ptr_load_val_i(lv), .mem_wr_o(wr),
      .ptr0_o(p0), .ptr1_o(p1), .status_o(so),
      .soft_reset_cause_flag_o(fl), .dev_reset_o(dr));
   task automatic chk(logic [31:0] g, logic [31:0] x);
      comparisons++;
      if (g !== x)
      begin
         errors++;
         $display("ERROR %0t %h %h", $time, g, x);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Load the pointer first so the model needs no history
   task automatic ex(iss_pkg::iss_op_e op, logic s, logic [1:0] m,
      logic [15:0] a);
      ld = 1;
      ls = s;
      lv = a;
      @(negedge clk);
      ld = 0;
      v = 1;
      ins = {op, s, m, 6'($random(seed))};
      w = 8'($random(seed));
      st = 8'($random(seed));
      e = op == iss_pkg::ISS_OP_STORE_REL ?
         a + {{10{ins.offset[5]}}, ins.offset} : a;
      if (op == iss_pkg::ISS_OP_STORE_MODE)
         a = m[0] ? a - 16'h0001 : a + 16'h0001;
      if (op == iss_pkg::ISS_OP_STORE_MODE && !m[1])
         e = a;
      @(negedge clk);
      v = 0;
      chk(32'(wr.en), 32'(op != 0));
      if (op != 0)
         chk(32'(wr), {7'h0, 1'b1, e, w});
      chk(32'(so), 32'(st));
      @(negedge clk);
      chk(32'(s ? p1 : p0), 32'(a));
   endtask
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 0;
      chk(32'(fl), 32'h0000_0001);
      $display("test 1 done");
      ex(iss_pkg::ISS_OP_STORE_MODE, 0, 2'h0, 16'hffff);
      ex(iss_pkg::ISS_OP_STORE_MODE, 1, 2'h1, 16'h0000);
      repeat (300)
         ex(iss_pkg::iss_op_e'($random(seed) & 3), 1'($random(seed)),
            2'($random(seed)), 16'($random(seed)));
      $display("test 2 done");
      ins.op = iss_pkg::ISS_OP_SOFT_RESET;
      v = 1;
      @(negedge clk);
      ins.op = iss_pkg::ISS_OP_ALIAS_WR;
      chk(32'({fl, dr, so}), 32'h0000_0100);
      @(negedge clk);
      v = 0;
      chk(32'({wr.en, dr, p0}), 32'h0001_0000);
      @(negedge clk);
      chk(32'({fl, dr}), 32'h0000_0000);
      $display("test 3 done");
      close_out;
   end
   // Run needs about 1000 cycles; allow four times that
   initial
   begin
      #200000;
      errors++;
      close_out;
   end
endmodule // iss_top_bench
`default_nettype wire

/* verif/iss_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module iss_top_props (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire iss_pkg::iss_instr_s instr_i,
   input wire logic [7:0] w_reg_i,
   input wire logic [7:0] status_i,
   input wire iss_pkg::iss_mem_wr_s mem_wr_o,
   input wire logic [15:0] ptr0_o,
   input wire logic [15:0] ptr1_o,
   input wire logic [7:0] status_o,
   input wire logic soft_reset_cause_flag_o,
   input wire logic dev_reset_o
);
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Nothing is taken while the soft reset pulse stands
   wire tk = instr_valid_i && !dev_reset_o;
   wire [2:0] op = instr_i.op;
   wire sm = tk && op == iss_pkg::ISS_OP_STORE_MODE && !instr_i.sel;
   wire sr = tk && op == iss_pkg::ISS_OP_SOFT_RESET;
   wire pre = !instr_i.addr_update_field[1];
   wire [15:0] stp = instr_i.addr_update_field[0] ? 16'hffff : 16'h0001;
   wire [15:0] ofs = {{10{instr_i.offset[5]}}, instr_i.offset};
   // Pulse of two cycles; pointers seen cleared in its second cycle, then it drops
   sequence s_pulse;
      dev_reset_o && !soft_reset_cause_flag_o ##1 dev_reset_o;
   endsequence
   sequence s_clear;
      ptr0_o == 16'h0000 && ptr1_o == 16'h0000 ##1 !dev_reset_o;
   endsequence
   AST_DATA: assert property (tk && !op[2] && op != 3'h0 |=>
      mem_wr_o.en && mem_wr_o.data == $past(w_reg_i)) else $error("data");
   AST_MODE: assert property (sm |=> mem_wr_o.addr == ptr0_o +
      ($past(pre) ? $past(stp) : 16'h0000)) else $error("mode");
   AST_WRAP: assert property (sm |=> ##1
      ptr0_o == $past(ptr0_o) + $past(stp, 2)) else $error("wrap");
   AST_STAT: assert property (!dev_reset_o && !sr |=>
      status_o == $past(status_i)) else $error("status");
   AST_SRST_STAT: assert property (sr |=> status_o == 8'h00)
      else $error("status not cleared by soft reset");
   AST_ALIAS: assert property (tk && instr_i.sel &&
      op == iss_pkg::ISS_OP_ALIAS_WR |=> mem_wr_o.addr == ptr1_o)
      else $error("alias");
   AST_SRST: assert property (sr |=> s_pulse ##0 s_clear)
      else $error("srst");
   AST_REL: assert property (tk && !instr_i.sel &&
      op == iss_pkg::ISS_OP_STORE_REL |=> mem_wr_o.addr ==
      ptr0_o + $past(ofs) ##1 $stable(ptr0_o)) else $error("rel");
endmodule // iss_top_props
bind iss_top iss_top_props i_iss_top_props (.*);
`default_nettype wire
